/* tb_top.sv */
// Self-checking bench for the touch key sensing block.
`timescale 1ns/1ps
module tb_top;
	import tkey_pkg::*;
	logic clk, rst_n, awv, wv, bready, arv, rready, awr, wrr, bv, arr, rv;
	logic [7:0] awaddr, araddr, v;
	logic [31:0] wdata, rdata, rdv;
	logic [1:0] bresp, rresp, rsp, brsp, mux;
	logic [3:0] pad_osc, pad_en;
	logic [9:0] trim;
	logic [2:0] freq;
	logic ref_osc, hop, filt, mfe, ref_run, key_run, irq;
	logic [7:0] ofs [5] = '{TKEY_OFS_CTRL0, TKEY_OFS_CTRL1, TKEY_OFS_TRIM_LO,
		TKEY_OFS_TRIM_HI, TKEY_OFS_CNT_HI};
	int n_fail = 0;
	int num_checks = 0;
	int cyc;
	tkey_sense u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awv),
		.O_AXI_AWREADY(awr), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'h1), .I_AXI_WVALID(wv),
		.O_AXI_WREADY(wrr), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bv), .I_AXI_BREADY(bready),
		.I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr), .O_AXI_RDATA(rdata),
		.O_AXI_RRESP(rresp), .O_AXI_RVALID(rv), .I_AXI_RREADY(rready), .I_PAD_OSC(pad_osc),
		.I_REF_OSC(ref_osc), .O_PAD_ENABLE(pad_en), .O_KEY_MUX_SELECT(mux),
		.O_REF_CAP_TRIM(trim), .O_OSC_FREQ_SELECT(freq), .O_HOP_HW_CONTROL(hop),
		.O_FILTER_ENABLE(filt), .O_MULTI_FREQ_ENABLE(mfe), .O_REF_OSC_RUN(ref_run),
		.O_KEY_OSC_RUN(key_run), .O_IRQ(irq));
	tkey_pads u_pads (.i_clk(clk), .i_rst_n(rst_n), .i_key_run(key_run), .i_ref_run(ref_run),
		.o_pad_osc(pad_osc), .o_ref_osc(ref_osc));
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tmo(inout int n);
		n++;
		if (n > 2000) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic pa;
		logic pw;
		int n;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(posedge clk);
			if (awr === 1'b1) begin
				pa = 1'b0;
				awv <= 1'b0;
			end
			if (wrr === 1'b1) begin
				pw = 1'b0;
				wv <= 1'b0;
			end
			tmo(n);
		end
		do begin
			@(posedge clk);
			tmo(n);
		end while (bv !== 1'b1);
		brsp = bresp;
		bready <= 1'b0;
		// One idle edge keeps a following request from driving a signal twice in one step.
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			tmo(n);
		end while (arr !== 1'b1);
		arv <= 1'b0;
		do begin
			@(posedge clk);
			tmo(n);
		end while (rv !== 1'b1);
		rdv = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic run(input logic [7:0] pre, input logic [7:0] c1, input logic [7:0] c0);
		int n;
		n = 0;
		wr(TKEY_OFS_PRESET, pre);
		wr(TKEY_OFS_CTRL0, c0);
		wr(TKEY_OFS_CTRL1, c1);
		wr(TKEY_OFS_RUNCTL, 8'h00);
		wr(TKEY_OFS_RUNCTL, 8'h20);
		while (key_run !== 1'b1) begin
			@(posedge clk);
			tmo(n);
		end
		cyc = 0;
		while (key_run === 1'b1) begin
			@(posedge clk);
			cyc++;
			tmo(n);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		{awv, wv, bready, arv, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (ofs[i]) begin
			rd(ofs[i]);
			chk(rdv, 32'h0);
		end
		wr(TKEY_OFS_TRIM_HI, 8'hFF);
		chk(brsp, TKEY_RESP_OKAY);
		wr(TKEY_OFS_TRIM_LO, 8'hA5);
		chk(trim, 10'h3A5);
		rd(TKEY_OFS_TRIM_HI);
		chk(rdv, 32'h3);
		wr(TKEY_OFS_CTRL1, 8'hFF);
		rd(TKEY_OFS_CTRL1);
		chk(rdv, 32'hBF);
		chk(pad_en, 4'hF);
		for (int i = 0; i < 8; i++) begin
			v = {i[1:0], i[0], ~i[0], 1'b0, i[2:0]};
			wr(TKEY_OFS_CTRL0, v);
			chk({mux, mfe, filt, hop, freq}, v);
		end
		// No start has happened yet, so the hopping sequence still sits at its first step.
		wr(TKEY_OFS_CTRL0, 8'h0F);
		chk({hop, freq}, 4'h8);
		rd(8'h3C);
		chk(rsp, TKEY_RESP_SLVERR);
		chk(rdv, 32'h0);
		wr(TKEY_OFS_IRQ_MASK, 8'h01);
		// Slot of (256-255)*32 ticks at one tick per four clocks: 128 clocks, pad rise every two.
		run(8'hFF, 8'hB1, 8'h00);
		chk(ref_run, 1'b0);
		chk(cyc >= 122 && cyc <= 134, 1);
		rd(TKEY_OFS_RUNCTL);
		chk(rdv, 32'h60);
		rd(TKEY_OFS_CNT_LO);
		chk(rdv >= 58 && rdv <= 70, 1);
		rd(TKEY_OFS_CNT_HI);
		chk(rdv, 32'h0);
		chk(irq, 1'b1);
		wr(TKEY_OFS_RUNCTL, 8'h50);
		rd(TKEY_OFS_CNT_LO);
		chk(rdv, 32'h0);
		rd(TKEY_OFS_RUNCTL);
		chk(rdv, 32'h0);
		wr(TKEY_OFS_IRQ_STAT, 8'h03);
		chk(irq, 1'b0);
		wr(TKEY_OFS_IRQ_MASK, 8'h00);
		// Reference ticks every two clocks, (256-254)*32 of them; pad one is selected but disabled.
		// Hardware hopping is on, so this start moves the frequency code to its second step.
		run(8'hFE, 8'h32, 8'h08);
		chk(cyc >= 122 && cyc <= 134, 1);
		chk({hop, freq}, 4'h9);
		rd(TKEY_OFS_CNT_LO);
		chk(rdv, 32'h0);
		rd(TKEY_OFS_IRQ_STAT);
		chk(rdv, 32'h1);
		chk(irq, 1'b0);
		wr(TKEY_OFS_RUNCTL, 8'h50);
		wr(TKEY_OFS_IRQ_STAT, 8'h03);
		stop_test();
	end
endmodule

/* tkey_edge_det.sv */
// Rising edge detector for the synchronous oscillator sample inputs.
`timescale 1ns/1ps
module tkey_edge_det #(
	parameter int WIDTH = 5
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_level,
	output logic [WIDTH-1:0] o_rise
);
	logic [WIDTH-1:0] prev_reg;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("Edge detector width must be positive.");
		end
	endgenerate

	generate
		for (genvar g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					prev_reg[g] <= 1'b0;
					o_rise[g] <= 1'b0;
				end else begin
					prev_reg[g] <= i_level[g];
					o_rise[g] <= i_level[g] & ~prev_reg[g];
				end
			end
		end
	endgenerate
endmodule

/* tkey_pads.sv */
// Behavioural touch pads and reference oscillator facing the sensing block.
`timescale 1ns/1ps
module tkey_pads (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_key_run,
	input wire logic i_ref_run,
	output logic [3:0] o_pad_osc,
	output logic o_ref_osc
);
	// A stopped oscillator rests low, so no stale level can be taken for an edge.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pad_osc <= 4'h0;
			o_ref_osc <= 1'b0;
		end else begin
			o_pad_osc <= i_key_run ? ~o_pad_osc : 4'h0;
			o_ref_osc <= i_ref_run ? ~o_ref_osc : 1'b0;
		end
	end
endmodule

/* tkey_pkg.sv */
// Constants, register map and field layout of the capacitive touch key sensing block.
// What this block does
// R01 - Upper count byte is a read-only register reset to zero; low byte separate.
// R02 - Ten-bit trim over low byte and two-bit high byte sets reference capacitance.
// R03 - Two-bit key select routes pad one to four to the counter, codes 00 to 11.
// R04 - Control byte holds filter enable at bit 4, multi-frequency enable at bit 5.
// R05 - Hopping bit set lets hardware hop frequency, ignoring the select field.
// R06 - Three-bit field picks oscillator frequency, 1380kHz at 000 to 2740kHz at 111.
// R07 - Slot clock select bit 7: reference oscillator when clear, system clock by four when set.
// R08 - Reference oscillator runs only with bit 5 set, key oscillator only with bit 4.
// R09 - Pad enable bits 3 down to 0 enable pads four down to one, reset clear.
// R10 - Count sense oscillator cycles during the fixed reference interval.
// R11 - One interrupt output, raised when the slot counter overflows at interval end or the sense counter overflows, each source masked.
// R12 - Slot counter overflow stops both oscillators and switches off all counters.
// R13 - A rising start bit enables and synchronises the oscillators and counters.
// R14 - Unimplemented bits, control one bit 6 and trim high bits 7 to 2, read zero.
// R15 - Clearing start clears sense, reference and slot counters, not the slot timer.
// R16 - Slot overflow sets overflow and interrupt flags; only software clears them.
// R17 - Slot period is 256 minus preset, times 32 slot clock cycles.
// R18 - Sense counter overflow sets a sticky flag cleared only by software.
// R19 - Sense counter counts only selected pad edges while a measurement runs.
package tkey_pkg;
	localparam int TKEY_ADDR_W = 8;
	localparam logic [7:0] TKEY_OFS_CTRL0 = 8'h00;
	localparam logic [7:0] TKEY_OFS_CTRL1 = 8'h04;
	localparam logic [7:0] TKEY_OFS_TRIM_LO = 8'h08;
	localparam logic [7:0] TKEY_OFS_TRIM_HI = 8'h0C;
	localparam logic [7:0] TKEY_OFS_CNT_LO = 8'h10;
	localparam logic [7:0] TKEY_OFS_CNT_HI = 8'h14;
	localparam logic [7:0] TKEY_OFS_PRESET = 8'h18;
	localparam logic [7:0] TKEY_OFS_RUNCTL = 8'h1C;
	localparam logic [7:0] TKEY_OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] TKEY_OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] TKEY_OFS_REF_CNT = 8'h28;
	localparam int TKEY_MUX_LSB = 6;
	localparam int TKEY_MULTI_FREQ_BIT = 5;
	localparam int TKEY_FILTER_BIT = 4;
	localparam int TKEY_HOP_BIT = 3;
	localparam int TKEY_TSS_BIT = 7;
	localparam int TKEY_REF_EN_BIT = 5;
	localparam int TKEY_KEY_EN_BIT = 4;
	localparam int TKEY_START_BIT = 5;
	localparam int TKEY_SLOT_OVF_BIT = 6;
	localparam int TKEY_CNT_OVF_BIT = 4;
	localparam int TKEY_IRQ_SLOT = 0;
	localparam int TKEY_IRQ_CNT = 1;
	localparam logic [7:0] TKEY_CTRL1_MASK = 8'hBF;
	localparam logic [7:0] TKEY_TRIM_HI_MASK = 8'h03;
	localparam logic [7:0] TKEY_RST_BYTE = 8'h00;
	localparam logic [1:0] TKEY_SYS_DIV_LAST = 2'h3;
	localparam logic [1:0] TKEY_RESP_OKAY = 2'h0;
	localparam logic [1:0] TKEY_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {TKEY_IDLE, TKEY_RUN, TKEY_DONE} tkey_state_t;
endpackage

/* tkey_sense.sv */
// Touch key sensing top: register slave, measurement control, counters and interrupt.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tkey_sense (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic [tkey_pkg::TKEY_ADDR_W-1:0] I_AXI_AWADDR,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	output logic [1:0] O_AXI_BRESP,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic [tkey_pkg::TKEY_ADDR_W-1:0] I_AXI_ARADDR,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	input wire logic [3:0] I_PAD_OSC,
	input wire logic I_REF_OSC,
	output logic [3:0] O_PAD_ENABLE,
	output logic [1:0] O_KEY_MUX_SELECT,
	output logic [9:0] O_REF_CAP_TRIM,
	output logic [2:0] O_OSC_FREQ_SELECT,
	output logic O_HOP_HW_CONTROL,
	output logic O_FILTER_ENABLE,
	output logic O_MULTI_FREQ_ENABLE,
	output logic O_REF_OSC_RUN,
	output logic O_KEY_OSC_RUN,
	output logic O_IRQ
);
	import tkey_pkg::*;

	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] trim_lo_reg;
	logic [1:0] trim_hi_reg;
	logic [7:0] preset_reg;
	logic start_reg;
	logic start_d_reg;
	logic slot_ovf_reg;
	logic cnt_ovf_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic [15:0] sense_cnt_reg;
	logic [15:0] ref_cnt_reg;
	logic [1:0] div_cnt_reg;
	logic [2:0] hop_reg;
	tkey_state_t state_reg;
	tkey_state_t state_next;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;

	logic wr_fire;
	logic rd_fire;
	logic wr_lane;
	logic [7:0] wbyte;
	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wr_trim_lo;
	logic wr_trim_hi;
	logic wr_preset;
	logic wr_runctl;
	logic wr_stat;
	logic wr_mask;
	logic wr_mapped;
	logic start_rise;
	logic running;
	logic slot_done;
	logic slot_tick;
	logic sense_inc;
	logic sense_wrap;
	logic [4:0] osc_rise;
	logic [1:0] key_sel;
	logic [7:0] rd_byte;
	logic rd_mapped;

	assign key_sel = ctrl0_reg[TKEY_MUX_LSB +: 2];
	assign start_rise = start_reg & ~start_d_reg;
	assign running = (state_reg == TKEY_RUN);

	// Write address and data are accepted together; the response follows both.
	assign wr_fire = awready_reg & wready_reg & I_AXI_AWVALID & I_AXI_WVALID;
	assign rd_fire = arready_reg & I_AXI_ARVALID;
	assign wr_lane = wr_fire & I_AXI_WSTRB[0];
	assign wbyte = I_AXI_WDATA[7:0];
	assign wr_ctrl0 = wr_lane && (I_AXI_AWADDR == TKEY_OFS_CTRL0);
	assign wr_ctrl1 = wr_lane && (I_AXI_AWADDR == TKEY_OFS_CTRL1);
	assign wr_trim_lo = wr_lane && (I_AXI_AWADDR == TKEY_OFS_TRIM_LO);
	assign wr_trim_hi = wr_lane && (I_AXI_AWADDR == TKEY_OFS_TRIM_HI);
	assign wr_preset = wr_lane && (I_AXI_AWADDR == TKEY_OFS_PRESET);
	assign wr_runctl = wr_lane && (I_AXI_AWADDR == TKEY_OFS_RUNCTL);
	assign wr_stat = wr_lane && (I_AXI_AWADDR == TKEY_OFS_IRQ_STAT);
	assign wr_mask = wr_lane && (I_AXI_AWADDR == TKEY_OFS_IRQ_MASK);

	always_comb begin
		case (I_AXI_AWADDR)
			TKEY_OFS_CTRL0, TKEY_OFS_CTRL1, TKEY_OFS_TRIM_LO, TKEY_OFS_TRIM_HI,
			TKEY_OFS_CNT_LO, TKEY_OFS_CNT_HI, TKEY_OFS_PRESET, TKEY_OFS_RUNCTL,
			TKEY_OFS_IRQ_STAT, TKEY_OFS_IRQ_MASK, TKEY_OFS_REF_CNT: begin
				wr_mapped = 1'b1;
			end
			default: begin
				wr_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= TKEY_RESP_OKAY;
		end else begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? TKEY_RESP_OKAY : TKEY_RESP_SLVERR;
			end else if (bvalid_reg && I_AXI_BREADY) begin
				bvalid_reg <= 1'b0;
			end else if (!bvalid_reg && !awready_reg && I_AXI_AWVALID && I_AXI_WVALID) begin
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl0_reg <= TKEY_RST_BYTE;
			ctrl1_reg <= TKEY_RST_BYTE;
			trim_lo_reg <= TKEY_RST_BYTE;
			trim_hi_reg <= '0;
			preset_reg <= TKEY_RST_BYTE;
			irq_mask_reg <= '0;
		end else begin
			if (wr_ctrl0) begin
				ctrl0_reg <= wbyte; // R03
			end
			if (wr_ctrl1) begin
				ctrl1_reg <= wbyte & TKEY_CTRL1_MASK; // R14
			end
			if (wr_trim_lo) begin
				trim_lo_reg <= wbyte; // R02
			end
			if (wr_trim_hi) begin
				trim_hi_reg <= wbyte[1:0]; // R02
			end
			if (wr_preset) begin
				preset_reg <= wbyte;
			end
			if (wr_mask) begin
				irq_mask_reg <= wbyte[1:0];
			end
		end
	end

	// Start is plain read/write; its rising edge arms a measurement.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			start_reg <= 1'b0;
			start_d_reg <= 1'b0;
		end else begin
			if (wr_runctl) begin
				start_reg <= wbyte[TKEY_START_BIT];
			end
			start_d_reg <= start_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TKEY_IDLE: begin
				if (start_rise) begin
					state_next = TKEY_RUN; // R13
				end
			end
			TKEY_RUN: begin
				if (!start_reg) begin
					state_next = TKEY_IDLE;
				end else if (slot_done) begin
					state_next = TKEY_DONE; // R12
				end
			end
			TKEY_DONE: begin
				if (!start_reg) begin
					state_next = TKEY_IDLE;
				end
			end
			default: begin
				state_next = TKEY_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_reg <= TKEY_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	tkey_edge_det #(
		.WIDTH(5)
	) u_edges (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_level({I_REF_OSC, I_PAD_OSC}),
		.o_rise(osc_rise)
	);

	// The divider restarts with each measurement so every slot starts in phase.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			div_cnt_reg <= '0;
		end else if (start_rise || !running) begin
			div_cnt_reg <= '0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 1'b1;
		end
	end

	assign slot_tick = ctrl1_reg[TKEY_TSS_BIT] ? (div_cnt_reg == TKEY_SYS_DIV_LAST) :
		(osc_rise[4] & ctrl1_reg[TKEY_REF_EN_BIT]); // R07

	tkey_slot_timer #(
		.TIMER_W(8),
		.SLOT_W(5)
	) u_slot (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(start_rise),
		.i_clear(~start_reg),
		.i_run(running),
		.i_tick(slot_tick),
		.i_preset(preset_reg),
		.o_done(slot_done)
	);

	// Only the selected pad's enabled oscillator is counted, and only mid-measurement.
	assign sense_inc = running && ctrl1_reg[TKEY_KEY_EN_BIT] && ctrl1_reg[key_sel] &&
		osc_rise[key_sel]; // R19
	assign sense_wrap = sense_inc && (&sense_cnt_reg);

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sense_cnt_reg <= '0;
			ref_cnt_reg <= '0;
		end else if (!start_reg || start_rise) begin
			sense_cnt_reg <= '0; // R15
			ref_cnt_reg <= '0;
		end else if (running) begin
			ref_cnt_reg <= ref_cnt_reg + 1'b1;
			if (sense_inc) begin
				sense_cnt_reg <= sense_cnt_reg + 1'b1; // R10
			end
		end
	end

	// A set in the same cycle as a software clear wins, so no event is lost.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			slot_ovf_reg <= 1'b0;
			cnt_ovf_reg <= 1'b0;
			irq_stat_reg <= '0;
		end else begin
			if (slot_done) begin
				slot_ovf_reg <= 1'b1; // R16
			end else if (wr_runctl && wbyte[TKEY_SLOT_OVF_BIT]) begin
				slot_ovf_reg <= 1'b0;
			end
			if (sense_wrap) begin
				cnt_ovf_reg <= 1'b1; // R18
			end else if (wr_runctl && wbyte[TKEY_CNT_OVF_BIT]) begin
				cnt_ovf_reg <= 1'b0;
			end
			if (slot_done) begin
				irq_stat_reg[TKEY_IRQ_SLOT] <= 1'b1; // R11
			end else if (wr_stat && wbyte[TKEY_IRQ_SLOT]) begin
				irq_stat_reg[TKEY_IRQ_SLOT] <= 1'b0;
			end
			if (sense_wrap) begin
				irq_stat_reg[TKEY_IRQ_CNT] <= 1'b1;
			end else if (wr_stat && wbyte[TKEY_IRQ_CNT]) begin
				irq_stat_reg[TKEY_IRQ_CNT] <= 1'b0;
			end
		end
	end

	// Hardware hopping steps to the next frequency code at each measurement start.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			hop_reg <= '0;
		end else if (start_rise && ctrl0_reg[TKEY_HOP_BIT]) begin
			hop_reg <= hop_reg + 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PAD_ENABLE <= '0;
			O_KEY_MUX_SELECT <= '0;
			O_REF_CAP_TRIM <= '0;
			O_OSC_FREQ_SELECT <= '0;
			O_HOP_HW_CONTROL <= 1'b0;
			O_FILTER_ENABLE <= 1'b0;
			O_MULTI_FREQ_ENABLE <= 1'b0;
			O_REF_OSC_RUN <= 1'b0;
			O_KEY_OSC_RUN <= 1'b0;
			O_IRQ <= 1'b0;
		end else begin
			O_PAD_ENABLE <= ctrl1_reg[3:0]; // R09
			O_KEY_MUX_SELECT <= key_sel; // R03
			O_REF_CAP_TRIM <= {trim_hi_reg, trim_lo_reg}; // R02
			O_OSC_FREQ_SELECT <= ctrl0_reg[TKEY_HOP_BIT] ? hop_reg : ctrl0_reg[2:0]; // R05 R06
			O_HOP_HW_CONTROL <= ctrl0_reg[TKEY_HOP_BIT]; // R05
			O_FILTER_ENABLE <= ctrl0_reg[TKEY_FILTER_BIT]; // R04
			O_MULTI_FREQ_ENABLE <= ctrl0_reg[TKEY_MULTI_FREQ_BIT]; // R04
			O_REF_OSC_RUN <= ctrl1_reg[TKEY_REF_EN_BIT] && (state_next == TKEY_RUN); // R08 R12
			O_KEY_OSC_RUN <= ctrl1_reg[TKEY_KEY_EN_BIT] && (state_next == TKEY_RUN); // R08 R12
			O_IRQ <= |(irq_stat_reg & irq_mask_reg); // R11
		end
	end

	always_comb begin
		rd_mapped = 1'b1;
		case (I_AXI_ARADDR)
			TKEY_OFS_CTRL0: rd_byte = ctrl0_reg;
			TKEY_OFS_CTRL1: rd_byte = ctrl1_reg & TKEY_CTRL1_MASK; // R14
			TKEY_OFS_TRIM_LO: rd_byte = trim_lo_reg;
			TKEY_OFS_TRIM_HI: rd_byte = {6'h00, trim_hi_reg} & TKEY_TRIM_HI_MASK; // R14
			TKEY_OFS_CNT_LO: rd_byte = sense_cnt_reg[7:0];
			TKEY_OFS_CNT_HI: rd_byte = sense_cnt_reg[15:8]; // R01
			TKEY_OFS_PRESET: rd_byte = preset_reg;
			TKEY_OFS_RUNCTL: rd_byte = {1'b0, slot_ovf_reg, start_reg, cnt_ovf_reg, 4'h0};
			TKEY_OFS_IRQ_STAT: rd_byte = {6'h00, irq_stat_reg};
			TKEY_OFS_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
			TKEY_OFS_REF_CNT: rd_byte = 8'h00;
			default: begin
				rd_byte = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= TKEY_RESP_OKAY;
			rdata_reg <= '0;
		end else begin
			arready_reg <= 1'b0;
			if (rd_fire) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= rd_mapped ? TKEY_RESP_OKAY : TKEY_RESP_SLVERR;
				rdata_reg <= (I_AXI_ARADDR == TKEY_OFS_REF_CNT) ? {16'h0000, ref_cnt_reg} :
					{24'h000000, rd_byte};
			end else if (rvalid_reg && I_AXI_RREADY) begin
				rvalid_reg <= 1'b0;
			end else if (!rvalid_reg && !arready_reg && I_AXI_ARVALID) begin
				arready_reg <= 1'b1;
			end
		end
	end

	assign O_AXI_AWREADY = awready_reg;
	assign O_AXI_WREADY = wready_reg;
	assign O_AXI_BVALID = bvalid_reg;
	assign O_AXI_BRESP = bresp_reg;
	assign O_AXI_ARREADY = arready_reg;
	assign O_AXI_RVALID = rvalid_reg;
	assign O_AXI_RRESP = rresp_reg;
	assign O_AXI_RDATA = rdata_reg;
endmodule

/* tkey_sense_asserts.sv */
// Port-level property checker for the touch key sensing block.
`timescale 1ns/1ps
module tkey_sense_asserts (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic [tkey_pkg::TKEY_ADDR_W-1:0] I_AXI_AWADDR,
	input wire logic I_AXI_AWVALID,
	input wire logic O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic I_AXI_WVALID,
	input wire logic O_AXI_WREADY,
	input wire logic [3:0] O_PAD_ENABLE,
	input wire logic [1:0] O_KEY_MUX_SELECT,
	input wire logic [9:0] O_REF_CAP_TRIM,
	input wire logic [2:0] O_OSC_FREQ_SELECT,
	input wire logic O_HOP_HW_CONTROL,
	input wire logic O_FILTER_ENABLE,
	input wire logic O_REF_OSC_RUN,
	input wire logic O_KEY_OSC_RUN,
	input wire logic O_IRQ
);
	import tkey_pkg::*;
	logic whs;
	logic [8:0] wsel;
	assign whs = I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY;
	// The handshake travels as an argument, so the properties see its sampled value.
	assign wsel = {~whs, I_AXI_AWADDR};
	function automatic logic wa(input logic [8:0] sel, input logic [7:0] ofs);
		return sel == {1'b0, ofs};
	endfunction
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// A configuration output moves two edges after the write handshake: register, then pin flop.
	AST_MUX: assert property ($changed(O_KEY_MUX_SELECT) |->
		$past(wa(wsel, TKEY_OFS_CTRL0), 2))
		else $error("key select changed without a control zero write");
	AST_TRIM: assert property ($changed(O_REF_CAP_TRIM) |->
		$past(wa(wsel, TKEY_OFS_TRIM_LO) || wa(wsel, TKEY_OFS_TRIM_HI), 2))
		else $error("trim changed without a trim write");
	AST_PADEN: assert property ($changed(O_PAD_ENABLE) |->
		$past(wa(wsel, TKEY_OFS_CTRL1), 2))
		else $error("pad enables changed without a control one write");
	AST_FILT: assert property ($changed(O_FILTER_ENABLE) |->
		$past(wa(wsel, TKEY_OFS_CTRL0), 2))
		else $error("filter enable changed without a control zero write");
	AST_FREQ: assert property ($changed(O_OSC_FREQ_SELECT) && !O_HOP_HW_CONTROL |->
		$past(wa(wsel, TKEY_OFS_CTRL0), 2))
		else $error("frequency moved while software owns it");
	AST_START: assert property (wa(wsel, TKEY_OFS_RUNCTL) && I_AXI_WDATA[TKEY_START_BIT] |->
		##[1:4] O_KEY_OSC_RUN)
		else $error("start did not enable the key oscillator");
	AST_STOP: assert property (wa(wsel, TKEY_OFS_RUNCTL) && !I_AXI_WDATA[TKEY_START_BIT] |->
		##[1:3] (!O_KEY_OSC_RUN && !O_REF_OSC_RUN))
		else $error("clearing start left an oscillator running");
	AST_IRQ_STOP: assert property ($rose(O_IRQ) |-> !O_KEY_OSC_RUN && !O_REF_OSC_RUN)
		else $error("interrupt raised with an oscillator still running");
	AST_IRQ_END: assert property ($rose(O_IRQ) |->
		$past(O_KEY_OSC_RUN, 2) || $past(O_KEY_OSC_RUN, 3))
		else $error("interrupt raised without a measurement ending");
	AST_IRQ_CLR: assert property (wa(wsel, TKEY_OFS_IRQ_STAT) && I_AXI_WDATA[0] &&
		I_AXI_WDATA[1] |->
		##2 !O_IRQ)
		else $error("interrupt stayed high after status clear");
endmodule
bind tkey_sense tkey_sense_asserts u_chk (.I_CLK, .I_RST_N, .I_AXI_AWADDR, .I_AXI_AWVALID,
	.O_AXI_AWREADY, .I_AXI_WDATA, .I_AXI_WVALID, .O_AXI_WREADY, .O_PAD_ENABLE,
	.O_KEY_MUX_SELECT, .O_REF_CAP_TRIM, .O_OSC_FREQ_SELECT, .O_HOP_HW_CONTROL,
	.O_FILTER_ENABLE, .O_REF_OSC_RUN, .O_KEY_OSC_RUN, .O_IRQ);

/* tkey_slot_timer.sv */
// Eight-bit preset slot timer followed by the five-bit slot counter.
`timescale 1ns/1ps
module tkey_slot_timer #(
	parameter int TIMER_W = 8,
	parameter int SLOT_W = 5
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic i_clear,
	input wire logic i_run,
	input wire logic i_tick,
	input wire logic [TIMER_W-1:0] i_preset,
	output logic o_done
);
	logic [TIMER_W-1:0] timer_reg;
	logic [SLOT_W-1:0] slot_reg;

	generate
		if (TIMER_W < 1 || SLOT_W < 1) begin : g_bad_width
			$error("Slot timer widths must be positive.");
		end
	endgenerate

	// The timer reloads the preset on each wrap, so it counts 256 minus preset ticks.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timer_reg <= '0;
		end else if (i_load) begin
			timer_reg <= i_preset;
		end else if (i_run && i_tick) begin
			timer_reg <= (&timer_reg) ? i_preset : timer_reg + 1'b1; // R17
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slot_reg <= '0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_clear || i_load) begin
				slot_reg <= '0; // R15
			end else if (i_run && i_tick && (&timer_reg)) begin
				slot_reg <= slot_reg + 1'b1;
				o_done <= &slot_reg; // R17
			end
		end
	end
endmodule
